/* rtl/agb_pkg.sv */
// ==========================================================================
// constants shared by the afe global bias bank
package agb_pkg;

  // ========================================================================
  // bus geometry
  localparam int          ADDR_W    = 8;
  localparam int          DATA_W    = 32;
  localparam int          REG_W     = 16;

  // ========================================================================
  // register byte offsets and reset values
  localparam logic [7:0]  OFS_BIAS  = 8'h3c;
  localparam logic [7:0]  OFS_SLOT  = 8'h54;
  localparam logic [15:0] RST_BIAS  = 16'h3006;
  localparam logic [15:0] RST_SLOT  = 16'h0020;

  // ========================================================================
  // field positions, global bias register
  localparam int          BIAS_CATH_BIT = 9;
  localparam int          PD_LSB        = 3;
  localparam int          PD_W          = 6;
  // channel n (0-based, n>=1) is powered down by field bit n + PD_CH_BASE
  localparam int          PD_CH_BASE    = 2;

  // ========================================================================
  // field positions, slot cathode and integrate register
  localparam int          SB_ONE_BIT    = 15;
  localparam int          SA_ONE_BIT    = 14;
  localparam int          SLEEP_LSB     = 12;
  localparam int          SLOTB_LSB     = 10;
  localparam int          SLOTA_LSB     = 8;
  localparam int          OVR_BIT       = 7;

  // ========================================================================
  // channels and integrate masks
  localparam int          NUM_CH        = 4;
  localparam logic [3:0]  MASK_ALL_CH   = 4'hf;
  localparam logic [3:0]  MASK_CH1      = 4'h1;

  // ========================================================================
  // four-level cathode / anode code
  localparam logic [1:0]  LVL_1V8  = 2'h0;
  localparam logic [1:0]  LVL_1V3  = 2'h1;
  localparam logic [1:0]  LVL_1V55 = 2'h2;
  localparam logic [1:0]  LVL_0V   = 2'h3;

  // ========================================================================
  // operating phase reported by the slot sequencer
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_SLEEP,
    PH_SLOT_A,
    PH_SLOT_B
  } agb_phase_t;

endpackage

/* rtl/agb_avmm_slave.sv */
`timescale 1ns/1ns
// ==========================================================================
// avalon-mm handshake: one wait cycle, then a one-cycle acknowledge
module agb_avmm_slave (
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      reset,
  // bus request
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  // read data offered by the register file
  input  wire logic [agb_pkg::DATA_W-1:0] rd_value,
  // bus answer
  output logic                           avs_waitrequest,
  output logic [agb_pkg::DATA_W-1:0]     avs_readdata,
  // write strobe to the register file
  output logic                           wr_strobe
);

  logic                         wait_ff;
  logic                         nxt_wait;
  logic [agb_pkg::DATA_W-1:0]   rdata_ff;
  logic [agb_pkg::DATA_W-1:0]   nxt_rdata;
  logic                         req;

  // ========================================================================
  // handshake next state; waitrequest rests high so no request slips by
  always_comb begin
    req       = avs_read | avs_write;
    nxt_wait  = ~(req & wait_ff);
    nxt_rdata = rdata_ff;
    if (avs_read && wait_ff) begin
      nxt_rdata = rd_value;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wait_ff  <= 1'b1;
      rdata_ff <= '0;
    end else begin
      wait_ff  <= nxt_wait;
      rdata_ff <= nxt_rdata;
    end
  end

  // write lands on the edge where the master sees waitrequest low
  assign wr_strobe       = avs_write & ~wait_ff;
  assign avs_waitrequest = wait_ff;
  assign avs_readdata    = rdata_ff;

endmodule // agb_avmm_slave

/* rtl/agb_cathode_sel.sv */
`timescale 1ns/1ns
// ==========================================================================
// picks cathode and anode level codes from phase and bias settings
module agb_cathode_sel (
  // phase and settings
  input  wire agb_pkg::agb_phase_t phase,
  input  wire logic                global_cath,
  input  wire logic                override_en,
  input  wire logic [1:0]          sleep_lvl,
  input  wire logic [1:0]          slot_a_lvl,
  input  wire logic [1:0]          slot_b_lvl,
  // level codes
  output logic [1:0]               cath_lvl,
  output logic [1:0]               anode_lvl
);

  logic [1:0] global_lvl;

  // ========================================================================
  // global level, then per-phase override, then anode follow in sleep
  always_comb begin
    global_lvl = global_cath ? agb_pkg::LVL_1V8 : agb_pkg::LVL_1V3;
    cath_lvl   = global_lvl;
    anode_lvl  = agb_pkg::LVL_1V3;
    if (override_en) begin
      case (phase)
        agb_pkg::PH_SLEEP:  cath_lvl = sleep_lvl;
        agb_pkg::PH_SLOT_A: cath_lvl = slot_a_lvl;
        agb_pkg::PH_SLOT_B: cath_lvl = slot_b_lvl;
        default:            cath_lvl = global_lvl;
      endcase
    end
    // slots keep anode at 1.3 v; sleep removes all diode bias
    if (phase == agb_pkg::PH_SLEEP) begin
      anode_lvl = cath_lvl;
    end
  end

endmodule // agb_cathode_sel

/* rtl/agb_top.sv */
// Functional notes
// - global bit: clear 1.3 V, set 1.8 V
// - powerdown 0x38 drops channels 2-4, zero none
// - slot B bit selects channel one integration
// - slot A bit selects channel one integration
// - override: sleep field drives cathode in sleep
// - in sleep anode follows cathode
// - override: slot B cathode field, anode 1.3 V
// - override: slot A cathode field, anode 1.3 V
// - override bit picks per-phase fields over global
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ns
module agb_top (
  // clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        reset,
  // avalon-mm slave
  input  wire logic [agb_pkg::ADDR_W-1:0]  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [agb_pkg::DATA_W-1:0]  avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic [agb_pkg::DATA_W-1:0]       avs_readdata,
  output logic                             avs_waitrequest,
  // phase from the slot sequencer, same clock
  input  wire agb_pkg::agb_phase_t         seq_phase,
  // photodiode bias controls
  output logic [1:0]                       cathode_level,
  output logic [1:0]                       anode_level,
  // channel power and integration
  output logic [agb_pkg::PD_W-1:0]         channel_powerdown_select,
  output logic [agb_pkg::NUM_CH-1:0]       channel_off,
  output logic [agb_pkg::NUM_CH-1:0]       slot_a_integrate_ch,
  output logic [agb_pkg::NUM_CH-1:0]       slot_b_integrate_ch
);

  // ========================================================================
  // declarations
  logic [agb_pkg::REG_W-1:0]  bias_ff;
  logic [agb_pkg::REG_W-1:0]  nxt_bias;
  logic [agb_pkg::REG_W-1:0]  slot_ff;
  logic [agb_pkg::REG_W-1:0]  nxt_slot;
  logic [agb_pkg::DATA_W-1:0] rd_value;
  logic                       wr_strobe;
  logic                       hit_bias;
  logic                       hit_slot;

  logic [1:0]                 cath_ff;
  logic [1:0]                 nxt_cath;
  logic [1:0]                 anode_ff;
  logic [1:0]                 nxt_anode;
  logic [agb_pkg::PD_W-1:0]   pd_sel_ff;
  logic [agb_pkg::PD_W-1:0]   nxt_pd_sel;
  logic [agb_pkg::NUM_CH-1:0] ch_off_ff;
  logic [agb_pkg::NUM_CH-1:0] nxt_ch_off;
  logic [agb_pkg::NUM_CH-1:0] int_a_ff;
  logic [agb_pkg::NUM_CH-1:0] nxt_int_a;
  logic [agb_pkg::NUM_CH-1:0] int_b_ff;
  logic [agb_pkg::NUM_CH-1:0] nxt_int_b;

  logic [1:0]                 sel_cath;
  logic [1:0]                 sel_anode;
  logic [agb_pkg::PD_W-1:0]   pd_field;
  logic                       override_en;

  // ========================================================================
  // byte-lane merge; only lanes 0 and 1 carry register bits
  function automatic logic [15:0] be_merge(
    input logic [15:0] old_val,
    input logic [31:0] wdata,
    input logic [3:0]  be
  );
    logic [15:0] res;
    res = old_val;
    if (be[0]) begin
      res[7:0] = wdata[7:0];
    end
    if (be[1]) begin
      res[15:8] = wdata[15:8];
    end
    return res;
  endfunction

  // ========================================================================
  // bus handshake
  agb_avmm_slave u_slave (
    .core_clk        (core_clk),
    .reset           (reset),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .rd_value        (rd_value),
    .avs_waitrequest (avs_waitrequest),
    .avs_readdata    (avs_readdata),
    .wr_strobe       (wr_strobe)
  );

  // ========================================================================
  // address decode and read mux; unmapped reads return zero
  always_comb begin
    hit_bias = (avs_address == agb_pkg::OFS_BIAS);
    hit_slot = (avs_address == agb_pkg::OFS_SLOT);
    rd_value = '0;
    if (hit_bias) begin
      rd_value = {16'h0000, bias_ff};
    end else if (hit_slot) begin
      rd_value = {16'h0000, slot_ff};
    end
  end

  // ========================================================================
  // register file next values; reserved bits are stored as written
  // so software can read back the defaults it is meant to keep
  always_comb begin
    nxt_bias = bias_ff;
    nxt_slot = slot_ff;
    if (wr_strobe && hit_bias) begin
      nxt_bias = be_merge(bias_ff, avs_writedata, avs_byteenable);
    end
    if (wr_strobe && hit_slot) begin
      nxt_slot = be_merge(slot_ff, avs_writedata, avs_byteenable);
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      bias_ff <= agb_pkg::RST_BIAS;
      slot_ff <= agb_pkg::RST_SLOT;
    end else begin
      bias_ff <= nxt_bias;
      slot_ff <= nxt_slot;
    end
  end

  // ========================================================================
  // field extraction
  assign pd_field    = bias_ff[agb_pkg::PD_LSB +: agb_pkg::PD_W];
  assign override_en = slot_ff[agb_pkg::OVR_BIT];

  // ========================================================================
  // cathode / anode selection
  agb_cathode_sel u_cath (
    .phase       (seq_phase),
    .global_cath (bias_ff[agb_pkg::BIAS_CATH_BIT]),
    .override_en (override_en),
    .sleep_lvl   (slot_ff[agb_pkg::SLEEP_LSB +: 2]),
    .slot_a_lvl  (slot_ff[agb_pkg::SLOTA_LSB +: 2]),
    .slot_b_lvl  (slot_ff[agb_pkg::SLOTB_LSB +: 2]),
    .cath_lvl    (sel_cath),
    .anode_lvl   (sel_anode)
  );

  // ========================================================================
  // per-channel power-down and integrate masks; channel 1 has no
  // power-down bit, so it always stays up for single-channel use
  genvar ch;
  generate
    for (ch = 0; ch < agb_pkg::NUM_CH; ch++) begin : g_ch
      if (ch == 0) begin : g_first
        assign nxt_ch_off[ch] = 1'b0;
      end else begin : g_rest
        assign nxt_ch_off[ch] = pd_field[ch + agb_pkg::PD_CH_BASE];
      end
      assign nxt_int_a[ch] = slot_ff[agb_pkg::SA_ONE_BIT]
                             ? agb_pkg::MASK_CH1[ch]
                             : agb_pkg::MASK_ALL_CH[ch];
      assign nxt_int_b[ch] = slot_ff[agb_pkg::SB_ONE_BIT]
                             ? agb_pkg::MASK_CH1[ch]
                             : agb_pkg::MASK_ALL_CH[ch];
    end
  endgenerate

  // ========================================================================
  // output next values
  always_comb begin
    nxt_cath   = sel_cath;
    nxt_anode  = sel_anode;
    nxt_pd_sel = pd_field;
  end

  // outputs registered: one cycle behind the phase, glitch-free drivers
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cath_ff   <= agb_pkg::LVL_1V3;
      anode_ff  <= agb_pkg::LVL_1V3;
      pd_sel_ff <= '0;
      ch_off_ff <= '0;
      int_a_ff  <= agb_pkg::MASK_ALL_CH;
      int_b_ff  <= agb_pkg::MASK_ALL_CH;
    end else begin
      cath_ff   <= nxt_cath;
      anode_ff  <= nxt_anode;
      pd_sel_ff <= nxt_pd_sel;
      ch_off_ff <= nxt_ch_off;
      int_a_ff  <= nxt_int_a;
      int_b_ff  <= nxt_int_b;
    end
  end

  assign cathode_level            = cath_ff;
  assign anode_level              = anode_ff;
  assign channel_powerdown_select = pd_sel_ff;
  assign channel_off              = ch_off_ff;
  assign slot_a_integrate_ch      = int_a_ff;
  assign slot_b_integrate_ch      = int_b_ff;

  // ========================================================================
  // checks on bias selection
  AST_GLOBAL_LOW: assert property (@(posedge core_clk)
    disable iff (reset)
    !slot_ff[agb_pkg::OVR_BIT] && !bias_ff[agb_pkg::BIAS_CATH_BIT]
    |=> cathode_level == agb_pkg::LVL_1V3)
    else $error("global cathode bit clear did not give 1.3 V");

  AST_GLOBAL_HIGH: assert property (@(posedge core_clk)
    disable iff (reset)
    !slot_ff[agb_pkg::OVR_BIT] && bias_ff[agb_pkg::BIAS_CATH_BIT]
    |=> cathode_level == agb_pkg::LVL_1V8)
    else $error("global cathode bit set did not give 1.8 V");

  AST_SLEEP_CATH: assert property (@(posedge core_clk)
    disable iff (reset)
    slot_ff[agb_pkg::OVR_BIT] && seq_phase == agb_pkg::PH_SLEEP
    |=> cathode_level == $past(slot_ff[13:12]))
    else $error("sleep cathode field not applied");

  AST_SLEEP_ANODE: assert property (@(posedge core_clk)
    disable iff (reset)
    seq_phase == agb_pkg::PH_SLEEP
    |=> anode_level == cathode_level)
    else $error("anode not tied to cathode in sleep");

  AST_SLOT_B: assert property (@(posedge core_clk)
    disable iff (reset)
    slot_ff[agb_pkg::OVR_BIT] && seq_phase == agb_pkg::PH_SLOT_B
    |=> cathode_level == $past(slot_ff[11:10])
        && anode_level == agb_pkg::LVL_1V3)
    else $error("slot B cathode or anode wrong");

  AST_SLOT_A: assert property (@(posedge core_clk)
    disable iff (reset)
    slot_ff[agb_pkg::OVR_BIT] && seq_phase == agb_pkg::PH_SLOT_A
    |=> cathode_level == $past(slot_ff[9:8])
        && anode_level == agb_pkg::LVL_1V3)
    else $error("slot A cathode or anode wrong");

  // ========================================================================
  // checks on channel power and integration
  AST_PD_THREE: assert property (@(posedge core_clk)
    disable iff (reset)
    pd_field == 6'h38 |=> channel_off == 4'he)
    else $error("0x38 did not power down channels 2 to 4");

  AST_PD_NONE: assert property (@(posedge core_clk)
    disable iff (reset)
    pd_field == 6'h00 |=> channel_off == 4'h0)
    else $error("zero select left a channel down");

  AST_INT_B: assert property (@(posedge core_clk)
    disable iff (reset)
    ##1 slot_b_integrate_ch == ($past(slot_ff[15]) ? 4'h1 : 4'hf))
    else $error("slot B integrate mask wrong");

  AST_INT_A: assert property (@(posedge core_clk)
    disable iff (reset)
    ##1 slot_a_integrate_ch == ($past(slot_ff[14]) ? 4'h1 : 4'hf))
    else $error("slot A integrate mask wrong");

  // select output mirrors its field one cycle late
  AST_PD_COPY: assert property (@(posedge core_clk)
    disable iff (reset)
    ##1 channel_powerdown_select == $past(pd_field))
    else $error("power-down select output does not follow its field");

  // channel 1 carries single-channel integration, so it never drops
  AST_CH1_ON: assert property (@(posedge core_clk)
    disable iff (reset)
    !channel_off[0])
    else $error("channel 1 powered down");

  // ========================================================================
  // bus checks: accepted writes land on the next cycle, gaps stay inert
  AST_WRITE_LANDS: assert property (@(posedge core_clk) disable iff (reset)
    avs_write && !avs_waitrequest && hit_slot
    && avs_byteenable[1:0] == 2'h3
    |=> slot_ff == $past(avs_writedata[15:0]))
    else $error("accepted write not stored");

  AST_BIAS_LANDS: assert property (@(posedge core_clk) disable iff (reset)
    avs_write && !avs_waitrequest && hit_bias
    && avs_byteenable[1:0] == 2'h3
    |=> bias_ff == $past(avs_writedata[15:0]))
    else $error("accepted write to bias register not stored");

  // unmapped writes are dropped silently, no error path exists
  AST_WRITE_GAP: assert property (@(posedge core_clk) disable iff (reset)
    avs_write && !avs_waitrequest && !hit_bias && !hit_slot
    |=> $stable(bias_ff) && $stable(slot_ff))
    else $error("unmapped write changed a register");

  // unmapped reads answer zero
  AST_READ_GAP: assert property (@(posedge core_clk) disable iff (reset)
    avs_read && avs_waitrequest && !hit_bias && !hit_slot
    |=> avs_readdata == 32'h0000_0000)
    else $error("unmapped read returned data");

  AST_RDATA_HIGH: assert property (@(posedge core_clk) disable iff (reset)
    avs_readdata[31:16] == 16'h0000)
    else $error("upper read data bits not zero");

  AST_ONE_WAIT: assert property (@(posedge core_clk) disable iff (reset)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held longer than one cycle");

  // idle bus: waitrequest rests high
  AST_WAIT_REST: assert property (@(posedge core_clk) disable iff (reset)
    !avs_read && !avs_write |=> avs_waitrequest)
    else $error("waitrequest low with no request");

endmodule // agb_top

/* dv/agb_testbench.sv */
`timescale 1ns/1ns
// ==========================================================================
// self-checking bench for the afe global bias bank
module testbench;

  typedef struct packed {
    logic [15:0]         r3c;
    logic [15:0]         r54;
    agb_pkg::agb_phase_t ph;
    logic [1:0]          cath;
    logic [1:0]          an;
    logic [3:0]          off;
    logic [3:0]          ia;
    logic [3:0]          ib;
  } agb_row_t;

  logic                      core_clk;
  logic                      reset;
  logic [7:0]                avs_address;
  logic                      avs_read;
  logic                      avs_write;
  logic [31:0]               avs_writedata;
  logic [3:0]                avs_byteenable;
  logic [31:0]               avs_readdata;
  logic                      avs_waitrequest;
  agb_pkg::agb_phase_t       seq_phase;
  logic [1:0]                cathode_level;
  logic [1:0]                anode_level;
  logic [5:0]                channel_powerdown_select;
  logic [3:0]                channel_off;
  logic [3:0]                slot_a_integrate_ch;
  logic [3:0]                slot_b_integrate_ch;
  int                        err_total;
  int                        n_tests;
  logic [31:0]               q;
  agb_row_t                  rows [0:22];
  logic [7:0]                gap_addr [0:3];

  agb_top dut_u (
    .core_clk                (core_clk),
    .reset                   (reset),
    .avs_address             (avs_address),
    .avs_read                (avs_read),
    .avs_write               (avs_write),
    .avs_writedata           (avs_writedata),
    .avs_byteenable          (avs_byteenable),
    .avs_readdata            (avs_readdata),
    .avs_waitrequest         (avs_waitrequest),
    .seq_phase               (seq_phase),
    .cathode_level           (cathode_level),
    .anode_level             (anode_level),
    .channel_powerdown_select(channel_powerdown_select),
    .channel_off             (channel_off),
    .slot_a_integrate_ch     (slot_a_integrate_ch),
    .slot_b_integrate_ch     (slot_b_integrate_ch)
  );

  // ========================================================================
  // 50 mhz clock
  initial core_clk = 1'b0;
  always #10 core_clk = ~core_clk;

  // ========================================================================
  // verdict and shared helpers
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one avalon access; request held until waitrequest sampled low
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    int i;
    @(posedge core_clk);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= ~wr;
    for (i = 0; i < 20; i++) begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (i == 20) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, 1'b1, 1'b0);
      complete_run();
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000, 4'hf);
    check(q, exp);
  endtask

  // two edges: one to take the cause, one for the registered output
  task automatic out_chk(input logic [1:0] c, input logic [1:0] an,
                         input logic [3:0] off, input logic [3:0] ia,
                         input logic [3:0] ib);
    repeat (2) @(posedge core_clk);
    #1;
    check({30'h0, cathode_level}, {30'h0, c});
    check({30'h0, anode_level}, {30'h0, an});
    check({28'h0, channel_off}, {28'h0, off});
    check({28'h0, slot_a_integrate_ch}, {28'h0, ia});
    check({28'h0, slot_b_integrate_ch}, {28'h0, ib});
  endtask

  // ========================================================================
  // main sequence: table first, then the awkward cases
  initial begin
    err_total      = 0;
    n_tests        = 0;
    reset          = 1'b1;
    avs_address    = 8'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0000_0000;
    avs_byteenable = 4'hf;
    seq_phase      = agb_pkg::PH_IDLE;
    // reserved fields always carry their defaults
    rows = '{
      '{16'h3006, 16'h0020, agb_pkg::PH_IDLE,   2'h1, 2'h1, 4'h0, 4'hf, 4'hf},
      '{16'h3206, 16'h0020, agb_pkg::PH_SLEEP,  2'h0, 2'h0, 4'h0, 4'hf, 4'hf},
      '{16'h3206, 16'h0020, agb_pkg::PH_SLOT_A, 2'h0, 2'h1, 4'h0, 4'hf, 4'hf},
      '{16'h31c6, 16'h0020, agb_pkg::PH_SLOT_A, 2'h1, 2'h1, 4'he, 4'hf, 4'hf},
      '{16'h3046, 16'h0020, agb_pkg::PH_SLOT_B, 2'h1, 2'h1, 4'h2, 4'hf, 4'hf},
      '{16'h303e, 16'h0020, agb_pkg::PH_IDLE,   2'h1, 2'h1, 4'h0, 4'hf, 4'hf},
      '{16'h3006, 16'h4020, agb_pkg::PH_SLOT_A, 2'h1, 2'h1, 4'h0, 4'h1, 4'hf},
      '{16'h3006, 16'h8020, agb_pkg::PH_SLOT_B, 2'h1, 2'h1, 4'h0, 4'hf, 4'h1},
      '{16'h3006, 16'hc020, agb_pkg::PH_IDLE,   2'h1, 2'h1, 4'h0, 4'h1, 4'h1},
      '{16'h3006, 16'h06a0, agb_pkg::PH_SLEEP,  2'h0, 2'h0, 4'h0, 4'hf, 4'hf},
      '{16'h3006, 16'h16a0, agb_pkg::PH_SLEEP,  2'h1, 2'h1, 4'h0, 4'hf, 4'hf},
      '{16'h3006, 16'h26a0, agb_pkg::PH_SLEEP,  2'h2, 2'h2, 4'h0, 4'hf, 4'hf},
      '{16'h3006, 16'h36a0, agb_pkg::PH_SLEEP,  2'h3, 2'h3, 4'h0, 4'hf, 4'hf},
      '{16'h3006, 16'h38a0, agb_pkg::PH_SLOT_A, 2'h0, 2'h1, 4'h0, 4'hf, 4'hf},
      '{16'h3006, 16'h39a0, agb_pkg::PH_SLOT_A, 2'h1, 2'h1, 4'h0, 4'hf, 4'hf},
      '{16'h3006, 16'h3aa0, agb_pkg::PH_SLOT_A, 2'h2, 2'h1, 4'h0, 4'hf, 4'hf},
      '{16'h3006, 16'h3ba0, agb_pkg::PH_SLOT_A, 2'h3, 2'h1, 4'h0, 4'hf, 4'hf},
      '{16'h3006, 16'h13a0, agb_pkg::PH_SLOT_B, 2'h0, 2'h1, 4'h0, 4'hf, 4'hf},
      '{16'h3006, 16'h17a0, agb_pkg::PH_SLOT_B, 2'h1, 2'h1, 4'h0, 4'hf, 4'hf},
      '{16'h3006, 16'h1ba0, agb_pkg::PH_SLOT_B, 2'h2, 2'h1, 4'h0, 4'hf, 4'hf},
      '{16'h3006, 16'h1fa0, agb_pkg::PH_SLOT_B, 2'h3, 2'h1, 4'h0, 4'hf, 4'hf},
      '{16'h3206, 16'h0fa0, agb_pkg::PH_IDLE,   2'h0, 2'h1, 4'h0, 4'hf, 4'hf},
      '{16'h3206, 16'h3f20, agb_pkg::PH_SLEEP,  2'h0, 2'h0, 4'h0, 4'hf, 4'hf}
    };
    gap_addr = '{8'h00, 8'h3d, 8'h55, 8'hff};
    // outputs while reset is held, then register defaults read back after release
    repeat (4) @(posedge core_clk);
    #1;
    check({30'h0, cathode_level}, 32'h0000_0001);
    check({28'h0, slot_b_integrate_ch}, 32'h0000_000f);
    @(posedge core_clk);
    reset <= 1'b0;
    rd_chk(8'h3c, 32'h0000_3006);
    rd_chk(8'h54, 32'h0000_0020);
    // table rows, accesses one idle cycle apart within a row, four idle cycles between rows
    foreach (rows[k]) begin
      bus(1'b1, 8'h3c, {16'h0, rows[k].r3c}, 4'hf);
      bus(1'b1, 8'h54, {16'h0, rows[k].r54}, 4'hf);
      rd_chk(8'h3c, {16'h0, rows[k].r3c});
      rd_chk(8'h54, {16'h0, rows[k].r54});
      @(posedge core_clk);
      seq_phase <= rows[k].ph;
      out_chk(rows[k].cath, rows[k].an, rows[k].off, rows[k].ia,
              rows[k].ib);
      check(32'(channel_powerdown_select), 32'(rows[k].r3c[8:3]));
    end
    // unmapped places: write dropped, read zero, no alias at neighbours
    foreach (gap_addr[j]) begin
      bus(1'b1, gap_addr[j], 32'h0000_ffff, 4'hf);
      rd_chk(gap_addr[j], 32'h0000_0000);
    end
    rd_chk(8'h3c, 32'h0000_3206);
    rd_chk(8'h54, 32'h0000_3f20);
    // upper lane only: integrate bits change, override bit in the lower byte kept clear
    bus(1'b1, 8'h54, 32'h0000_c0ff, 4'h2);
    rd_chk(8'h54, 32'h0000_c020);
    out_chk(2'h0, 2'h0, 4'h0, 4'h1, 4'h1);
    // reset in mid-run restores defaults and the 1.3 v bias
    @(posedge core_clk);
    reset <= 1'b1;
    out_chk(2'h1, 2'h1, 4'h0, 4'hf, 4'hf);
    check(32'(channel_powerdown_select), 32'h0000_0000);
    @(posedge core_clk);
    reset <= 1'b0;
    rd_chk(8'h54, 32'h0000_0020);
    rd_chk(8'h3c, 32'h0000_3006);
    complete_run();
  end

endmodule // testbench
